// >>> keb_pkg.sv
// Constants and types for the key event buffer with auto-repeat.
// Assumes a 200 MHz clock; used by keb_key_event_buffer and its bench.
`default_nettype none
package keb_pkg;

  // ----------------------------------------------------------------
  // Storage geometry
  // ----------------------------------------------------------------
  localparam int          DEPTH       = 16;
  localparam int          PTR_W       = 5;
  localparam int          KEY_W       = 7;
  localparam int          NUM_KEYS    = 128;
  localparam logic [PTR_W-1:0] FULL_CNT = 5'h10;
  localparam logic [PTR_W-1:0] ZERO_CNT = 5'h00;
  localparam logic [PTR_W-1:0] ONE_CNT  = 5'h01;
  localparam logic [1:0]  LEN_ONE     = 2'h1;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  OVERRUN_DEF = 8'h00;
  localparam logic [7:0]  CMD_ENABLE  = 8'hf4;
  localparam logic [7:0]  BREAK_PFX   = 8'hf0;
  localparam logic [7:0]  EXT_PFX     = 8'he0;
  localparam logic [KEY_W-1:0] NO_KEY = 7'h7f;

  // ----------------------------------------------------------------
  // Timing: 1 ms tick at 200 MHz
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ     = 200;
  localparam int          TICK_US     = 1000;
  localparam int          TICK_CYC    = CLK_MHZ * TICK_US;
  localparam int          TICK_W      = 18;
  localparam int          DELAY_MS    = 500;
  localparam int          RATE_MS     = 92;   // repeats every 93 ms, 10.8 characters per second
  localparam int          MS_W        = 11;

  // Per-key type: bit 0 repeats, bit 1 sends break
  localparam logic [1:0]  TYPE_DEF    = 2'h3;
  localparam int          TYPE_RPT    = 0;
  localparam int          TYPE_BRK    = 1;

  // Line protocol chosen at power-on
  localparam logic [1:0]  PROTO_W     = 2'h2;

  typedef enum logic [1:0] {
    ST_SENSE = 2'b00,
    ST_IDLE  = 2'b01,
    ST_RUN   = 2'b11
  } keb_state_e;

endpackage
`default_nettype wire

// >>> keb_key_event_buffer.sv
// Key event buffer: orders key events into scan codes, holds them in a
// 16-entry store, and generates auto-repeat for the newest held key.
// Assumes key events come from a same-clock scanner; the serial framer
// outside drains the store and carries response bytes on its own path.
`timescale 1ns/100ps
`default_nettype none

module keb_key_event_buffer #(
  parameter logic [7:0]  OVERRUN_CODE = keb_pkg::OVERRUN_DEF,
  parameter logic [10:0] DELAY_MS_DEF = 11'(keb_pkg::DELAY_MS),
  parameter logic [10:0] RATE_MS_DEF  = 11'(keb_pkg::RATE_MS),
  parameter logic [6:0]  PAUSE_KEY    = 7'h62,
  parameter logic [17:0] TICK_COUNT   = 18'(keb_pkg::TICK_CYC)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Key scanner events
  input  wire logic        keyValid,
  input  wire logic        keyPress,
  input  wire logic [6:0]  keyIndex,
  input  wire logic [7:0]  keyMake,
  input  wire logic        keyExt,
  // Link side
  input  wire logic        lineClkIn,
  input  wire logic        lineDataIn,
  input  wire logic        outAllowed,
  input  wire logic        codeTaken,
  output logic             codeValid,
  output logic [7:0]       codeByte,
  input  wire logic        respValid,
  input  wire logic [7:0]  respIn,
  output logic             respOutValid,
  output logic [7:0]       respOut,
  // Commands: the enable byte is decoded here from cmdByte, the rest outside
  input  wire logic        cmdValid,
  input  wire logic [7:0]  cmdByte,
  input  wire logic        rateWe,
  input  wire logic [10:0] rateDelayMs,
  input  wire logic [10:0] ratePeriodMs,
  input  wire logic        scanSet3,
  input  wire logic        typeWe,
  input  wire logic [6:0]  typeKey,
  input  wire logic [1:0]  typeVal,
  // Status
  output logic             overrun,
  output logic [1:0]       lineProto,
  output logic [4:0]       fillLevel,
  output logic             scanning
);

  // ----------------------------------------------------------------
  // Input synchronisers for the link pins
  // ----------------------------------------------------------------
  logic [1:0] clkSync_ff;
  logic [1:0] datSync_ff;
  logic       outSync1_ff;
  logic       outSync_ff;

  // Two stages each; only stage two is read further on
  always_ff @(posedge clk) begin
    clkSync_ff  <= {clkSync_ff[0], lineClkIn};
    datSync_ff  <= {datSync_ff[0], lineDataIn};
    outSync1_ff <= outAllowed;
    outSync_ff  <= outSync1_ff;
  end

  // ----------------------------------------------------------------
  // State, store and repeat registers
  // ----------------------------------------------------------------
  keb_pkg::keb_state_e state_ff;
  logic [7:0]  mem_ff [keb_pkg::DEPTH];
  logic [3:0]  wrPtr_ff;
  logic [3:0]  rdPtr_ff;
  logic [4:0]  count_ff;
  logic        lock_ff;
  logic        ovr_ff;
  logic [6:0]  rptKey_ff;
  logic [7:0]  rptMake_ff;
  logic        rptExt_ff;
  logic        rptArmed_ff;
  logic        rptFirst_ff;
  logic [10:0] msCnt_ff;
  logic [17:0] tick_ff;
  logic [10:0] delayMs_ff;
  logic [10:0] periodMs_ff;
  logic [1:0]  ktype_ff [keb_pkg::NUM_KEYS];
  logic [1:0]  proto_ff;
  logic        oValid_ff;
  logic [7:0]  oByte_ff;
  logic        rValid_ff;
  logic [7:0]  rByte_ff;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  wire logic       flushCmd  = cmdValid && cmdByte == keb_pkg::CMD_ENABLE;
  wire logic       running   = state_ff == keb_pkg::ST_RUN;
  wire logic [1:0] kType     = scanSet3 ? ktype_ff[keyIndex] : keb_pkg::TYPE_DEF;
  wire logic       isPause   = keyIndex == PAUSE_KEY;
  wire logic       sendBreak = !keyPress && kType[keb_pkg::TYPE_BRK] && !isPause;
  wire logic       evtPress  = running && keyValid && keyPress;
  wire logic       evtCode   = running && keyValid && (keyPress || sendBreak);
  wire logic       tickMs    = tick_ff == 18'h00000;
  wire logic       rptHit    = rptArmed_ff && tickMs && msCnt_ff == 11'h000;
  // Repeat loses to a real key event in the same cycle; it recurs later
  wire logic       rptEvt    = rptHit && !evtCode && outSync_ff;

  // Byte sequence of the current event: [ext] [break prefix] make
  wire logic       useExt    = evtCode ? keyExt : rptExt_ff;
  wire logic       useBrk    = evtCode && !keyPress;
  wire logic [7:0] useMake   = evtCode ? keyMake : rptMake_ff;
  wire logic [1:0] seqLen    = 2'(keb_pkg::LEN_ONE + 2'(useExt) + 2'(useBrk));
  wire logic       doPush    = evtCode || rptEvt;

  // Store space check: whole sequence or nothing
  wire logic       drainNow  = oValid_ff && codeTaken;
  wire logic [4:0] freeSlots = 5'(keb_pkg::FULL_CNT - count_ff);
  wire logic       fits      = freeSlots >= 5'(seqLen);
  wire logic       pushOk    = doPush && !lock_ff && fits;
  // Overrun fires when the store is full or short; it claims a slot only when not full
  wire logic       pushOvr   = doPush && !lock_ff && !fits;

  // Byte selected for each of up to three positions
  function automatic logic [7:0] seqByte(input logic [1:0] pos, input logic ext,
                                         input logic brk, input logic [7:0] mk);
    logic [1:0] p;
    p = pos;
    seqByte = mk;
    if (ext && p == 2'h0) begin
      seqByte = keb_pkg::EXT_PFX;
    end else begin
      if (ext) begin
        p = p - 2'h1;
      end
      if (brk && p == 2'h0) begin
        seqByte = keb_pkg::BREAK_PFX;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Power-on sensing and run state
  // ----------------------------------------------------------------
  // Lines are sampled once after reset; both high picks the idle protocol
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= keb_pkg::ST_SENSE;
      proto_ff <= 2'h0;
    end else begin
      unique case (state_ff)
        keb_pkg::ST_SENSE: begin
          proto_ff <= {clkSync_ff[1], datSync_ff[1]};
          state_ff <= keb_pkg::ST_IDLE;
        end
        keb_pkg::ST_IDLE: begin
          state_ff <= keb_pkg::ST_RUN;
        end
        keb_pkg::ST_RUN: begin
          state_ff <= keb_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Scan code store
  // ----------------------------------------------------------------
  // Write a whole sequence in one cycle; the pointer math wraps at 16
  always_ff @(posedge clk) begin
    if (pushOk) begin
      for (int i = 0; i < 3; i++) begin
        if (2'(i) < seqLen) begin
          mem_ff[4'(wrPtr_ff + 4'(i))] <= seqByte(2'(i), useExt, useBrk, useMake);
        end
      end
    end else if (pushOvr && count_ff != keb_pkg::FULL_CNT) begin
      mem_ff[wrPtr_ff] <= OVERRUN_CODE;
    end
  end

  // Pointers, fill count and overrun lock
  always_ff @(posedge clk) begin
    if (srst || flushCmd) begin
      wrPtr_ff <= 4'h0;
      rdPtr_ff <= 4'h0;
      count_ff <= keb_pkg::ZERO_CNT;
      lock_ff  <= 1'b0;
      ovr_ff   <= 1'b0;
    end else begin
      if (pushOk) begin
        wrPtr_ff <= 4'(wrPtr_ff + 4'(seqLen));
      end else if (pushOvr && count_ff != keb_pkg::FULL_CNT) begin
        wrPtr_ff <= wrPtr_ff + 4'h1;
      end
      if (drainNow) begin
        rdPtr_ff <= rdPtr_ff + 4'h1;
      end
      count_ff <= 5'(count_ff
                   + (pushOk ? 5'(seqLen) : 5'h00)
                   + ((pushOvr && count_ff != keb_pkg::FULL_CNT) ? keb_pkg::ONE_CNT : 5'h00)
                   - (drainNow ? keb_pkg::ONE_CNT : 5'h00));
      // Lock holds until output is allowed again; a new overrun wins
      if (pushOvr) begin
        lock_ff <= 1'b1;
        ovr_ff  <= 1'b1;
      end else if (outSync_ff) begin
        lock_ff <= 1'b0;
      end
    end
  end

  // Output stage: present head byte while output is allowed
  always_ff @(posedge clk) begin
    if (srst || flushCmd) begin
      oValid_ff <= 1'b0;
      oByte_ff  <= 8'h00;
    end else if (!oValid_ff || codeTaken) begin
      oValid_ff <= outSync_ff && (count_ff > (drainNow ? keb_pkg::ONE_CNT : keb_pkg::ZERO_CNT));
      oByte_ff  <= mem_ff[drainNow ? rdPtr_ff + 4'h1 : rdPtr_ff];
    end
  end

  // Responses pass straight through, never touching the store
  always_ff @(posedge clk) begin
    if (srst) begin
      rValid_ff <= 1'b0;
      rByte_ff  <= 8'h00;
    end else begin
      rValid_ff <= respValid;
      rByte_ff  <= respIn;
    end
  end

  // ----------------------------------------------------------------
  // Auto-repeat
  // ----------------------------------------------------------------
  // A millisecond tick keeps the counters small at the cost of 1 ms jitter
  always_ff @(posedge clk) begin
    if (srst || tickMs) begin
      tick_ff <= TICK_COUNT - 18'h00001;
    end else begin
      tick_ff <= tick_ff - 18'h00001;
    end
  end

  // Newest press takes over; only its release or the enable flush stops the repeat
  always_ff @(posedge clk) begin
    if (srst || flushCmd) begin
      rptKey_ff   <= keb_pkg::NO_KEY;
      rptMake_ff  <= 8'h00;
      rptExt_ff   <= 1'b0;
      rptArmed_ff <= 1'b0;
      rptFirst_ff <= 1'b0;
      msCnt_ff    <= 11'h000;
    end else if (evtPress) begin
      rptKey_ff   <= keyIndex;
      rptMake_ff  <= keyMake;
      rptExt_ff   <= keyExt;
      rptArmed_ff <= kType[keb_pkg::TYPE_RPT] && !isPause;
      rptFirst_ff <= 1'b1;
      msCnt_ff    <= delayMs_ff;
    end else if (running && keyValid && !keyPress && keyIndex == rptKey_ff) begin
      rptArmed_ff <= 1'b0;
      rptKey_ff   <= keb_pkg::NO_KEY;
    end else if (rptArmed_ff && tickMs) begin
      if (msCnt_ff == 11'h000) begin
        msCnt_ff    <= periodMs_ff;
        rptFirst_ff <= 1'b0;
      end else begin
        msCnt_ff <= msCnt_ff - 11'h001;
      end
    end
  end

  // Delay and rate come from the system; reset picks the defaults
  always_ff @(posedge clk) begin
    if (srst) begin
      delayMs_ff  <= DELAY_MS_DEF;
      periodMs_ff <= RATE_MS_DEF;
    end else if (rateWe) begin
      delayMs_ff  <= rateDelayMs;
      periodMs_ff <= ratePeriodMs;
    end
  end

  // Per-key type table, writable only in set three
  always_ff @(posedge clk) begin
    for (int k = 0; k < keb_pkg::NUM_KEYS; k++) begin
      if (srst) begin
        ktype_ff[k] <= keb_pkg::TYPE_DEF;
      end else if (typeWe && scanSet3 && typeKey == 7'(k)) begin
        ktype_ff[k] <= typeVal;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign codeValid    = oValid_ff;
  assign codeByte     = oByte_ff;
  assign respOutValid = rValid_ff;
  assign respOut      = rByte_ff;
  assign overrun      = ovr_ff;
  assign lineProto    = proto_ff;
  assign fillLevel    = count_ff;
  assign scanning     = state_ff[1];  // Only the run state has this bit set

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_store_bound: assert property (@(posedge clk) disable iff (srst)
    count_ff <= keb_pkg::FULL_CNT) else $error("store over 16 entries");
  a_ovr_lock: assert property (@(posedge clk) disable iff (srst)
    lock_ff && !outSync_ff && !flushCmd |=> count_ff <= $past(count_ff))
    else $error("data entered while locked");
  a_whole_seq: assert property (@(posedge clk) disable iff (srst)
    doPush && !fits && !lock_ff && !flushCmd |=> ovr_ff && lock_ff)
    else $error("short space did not flag overrun");
  a_enable_flush: assert property (@(posedge clk) disable iff (srst)
    flushCmd |=> count_ff == keb_pkg::ZERO_CNT && !rptArmed_ff)
    else $error("enable did not flush");
  a_pause_norpt: assert property (@(posedge clk) disable iff (srst)
    evtPress && isPause && !flushCmd |=> !rptArmed_ff)
    else $error("pause key armed repeat");
  a_release_stop: assert property (@(posedge clk) disable iff (srst)
    running && keyValid && !keyPress && keyIndex == rptKey_ff && !flushCmd
    |=> !rptArmed_ff) else $error("repeat survived release");
  a_inhibit_norpt: assert property (@(posedge clk) disable iff (srst)
    rptHit && !outSync_ff |-> !pushOk || evtCode)
    else $error("repeat stored while inhibited");
  a_resp_pass: assert property (@(posedge clk) disable iff (srst)
    respValid |=> respOutValid && respOut == $past(respIn))
    else $error("response not passed");
  a_rate_load: assert property (@(posedge clk) disable iff (srst)
    rateWe |=> delayMs_ff == $past(rateDelayMs) && periodMs_ff == $past(ratePeriodMs))
    else $error("rate not loaded");
  a_drain_seq: assert property (@(posedge clk) disable iff (srst)
    drainNow && !flushCmd |=> rdPtr_ff == $past(rdPtr_ff) + 4'h1)
    else $error("drain pointer stuck");
  c_store_full: cover property (@(posedge clk) count_ff == keb_pkg::FULL_CNT);
  c_overrun: cover property (@(posedge clk) pushOvr);
  c_repeat: cover property (@(posedge clk) rptEvt && pushOk);
  c_drain: cover property (@(posedge clk) drainNow);

endmodule

`default_nettype wire

// >>> keb_host_model.sv
// Host-side model: grants keyboard output, takes head bytes, reports them.
// Assumes the bench clock; its requests change on the falling edge only.
`timescale 1ns/100ps
`default_nettype none

module keb_host_model (
  // Clock
  input  wire logic       clk,
  // Bench control
  input  wire logic       allow,
  input  wire logic       slow,
  // Buffer output side
  input  wire logic       codeValid,
  input  wire logic [7:0] codeByte,
  output logic            outAllowed,
  output logic            codeTaken,
  output logic            lineClk,
  output logic            lineData,
  // Bytes received
  output logic            gotStb,
  output logic [7:0]      gotByte
);
  logic [1:0] paceCnt;

  // Clock held low is the inhibit; data rests on its pull-up
  assign outAllowed = allow;
  assign lineClk    = allow;
  assign lineData   = 1'b1;

  // A slow host takes one byte in four cycles so the store backs up
  initial begin
    paceCnt   = 2'h0;
    codeTaken = 1'b0;
  end
  always @(negedge clk) begin
    paceCnt   <= paceCnt + 2'h1;
    codeTaken <= codeValid && allow && (!slow || paceCnt == 2'h3);
  end

  // Report each byte at the edge that consumed it
  initial gotStb = 1'b0;
  always @(posedge clk) begin
    gotStb  <= codeTaken && codeValid;
    gotByte <= codeByte;
  end
endmodule
`default_nettype wire

// >>> keb_key_event_buffer_tb_top.sv
// Self-checking bench for the key event buffer with auto-repeat.
// Assumes keb_pkg, the buffer and keb_host_model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module keb_key_event_buffer_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [17:0] TICKS = 18'h00004;  // 1 ms shortened to 4 cycles
  logic        clk, srst, keyValid, keyPress, keyExt, cmdValid, rateWe, scanSet3;
  logic        typeWe, respValid, outAllowed, codeTaken, codeValid, respOutValid;
  logic        overrun, scanning, lineClk, lineData, allow, slow, gotStb;
  logic [6:0]  keyIndex, typeKey;
  logic [7:0]  keyMake, cmdByte, respIn, codeByte, respOut, gotByte;
  logic [10:0] rateDelayMs, ratePeriodMs;
  logic [1:0]  typeVal, lineProto;
  logic [4:0]  fillLevel;
  logic [31:0] rng;
  logic [7:0]  expQ[$];
  logic [7:0]  gotQ[$];
  int          badCount, testsRun, cntA, cntB;

  keb_key_event_buffer #(.TICK_COUNT(TICKS)) uut (
    .clk(clk), .srst(srst), .keyValid(keyValid), .keyPress(keyPress),
    .keyIndex(keyIndex), .keyMake(keyMake), .keyExt(keyExt), .lineClkIn(lineClk),
    .lineDataIn(lineData), .outAllowed(outAllowed), .codeTaken(codeTaken),
    .codeValid(codeValid), .codeByte(codeByte), .respValid(respValid), .respIn(respIn),
    .respOutValid(respOutValid), .respOut(respOut), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .rateWe(rateWe), .rateDelayMs(rateDelayMs),
    .ratePeriodMs(ratePeriodMs), .scanSet3(scanSet3), .typeWe(typeWe),
    .typeKey(typeKey), .typeVal(typeVal), .overrun(overrun), .lineProto(lineProto),
    .fillLevel(fillLevel), .scanning(scanning));

  keb_host_model host (
    .clk(clk), .allow(allow), .slow(slow), .codeValid(codeValid), .codeByte(codeByte),
    .outAllowed(outAllowed), .codeTaken(codeTaken), .lineClk(lineClk),
    .lineData(lineData), .gotStb(gotStb), .gotByte(gotByte));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Collect what the host received, in arrival order
  always @(posedge clk) begin
    if (gotStb) gotQ.push_back(gotByte);
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Extended keys lead with e0, releases put f0 before the make code
  function automatic void addKey(input logic p, input logic ext, input logic [7:0] mk);
    if (ext) expQ.push_back(8'he0);
    if (!p) expQ.push_back(keb_pkg::BREAK_PFX);
    expQ.push_back(mk);
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic keyEv(input logic p, input logic [6:0] idx, input logic [7:0] mk,
                       input logic ext);
    @(negedge clk);
    keyValid = 1'b1;
    keyPress = p;
    keyIndex = idx;
    keyMake  = mk;
    keyExt   = ext;
    @(negedge clk);
    keyValid = 1'b0;
  endtask

  task automatic sendCmd(input logic [7:0] c);
    @(negedge clk);
    cmdValid = 1'b1;
    cmdByte  = c;
    @(negedge clk);
    cmdValid = 1'b0;
  endtask

  // Waits a bounded time, then lingers so stray extra bytes get caught too
  task automatic drainCmp(input string name);
    int i;
    i = 0;
    while (gotQ.size() < expQ.size() && i < 3000) begin
      @(negedge clk);
      i++;
    end
    repeat (20) @(negedge clk);
    check({name, " count"}, gotQ.size(), expQ.size());
    foreach (expQ[k]) if (k < gotQ.size()) check(name, gotQ[k], expQ[k]);
    gotQ.delete();
    expQ.delete();
  endtask

  task automatic finishTest;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog sized well above the roughly 1300 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    finishTest();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {srst, keyValid, keyPress, keyExt, cmdValid, rateWe, scanSet3} = 7'h40;
    {typeWe, respValid, allow, slow} = 4'h0;
    {keyIndex, typeKey, typeVal} = 16'h0000;
    {keyMake, cmdByte, respIn} = 24'h000000;
    {rateDelayMs, ratePeriodMs} = 22'h000000;
    rng = 32'he805;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    check("lineProto", lineProto, 2'h1);
    check("scanning", scanning, 1'b1);
    allow = 1'b1;
    // Random press and release pairs, some against a slow host
    for (int n = 0; n < 16; n++) begin
      rng = xs(rng);
      slow = rng[20];
      keyEv(1'b1, {1'b0, rng[5:0]}, {1'b0, rng[14:8]}, rng[16]);
      addKey(1'b1, rng[16], {1'b0, rng[14:8]});
      keyEv(1'b0, {1'b0, rng[5:0]}, {1'b0, rng[14:8]}, rng[16]);
      addKey(1'b0, rng[16], {1'b0, rng[14:8]});
      repeat (24) @(negedge clk);
    end
    drainCmp("stream");
    // Inhibited: 15 codes, an extended key that cannot fit, then a lost key
    slow = 1'b0;
    allow = 1'b0;
    repeat (4) @(negedge clk);
    for (int n = 0; n < 15; n++) keyEv(1'b1, 7'(n), 8'h10 + 8'(n), 1'b0);
    repeat (2) @(negedge clk);
    check("fill 15", fillLevel, 5'h0f);
    keyEv(1'b1, 7'h14, 8'h44, 1'b1);
    keyEv(1'b1, 7'h15, 8'h45, 1'b0);
    repeat (2) @(negedge clk);
    check("fill full", fillLevel, 5'h10);
    check("overrun", overrun, 1'b1);
    for (int n = 0; n < 15; n++) expQ.push_back(8'h10 + 8'(n));
    expQ.push_back(keb_pkg::OVERRUN_DEF);
    allow = 1'b1;
    drainCmp("overrun drain");
    keyEv(1'b1, 7'h1e, 8'h55, 1'b0);
    addKey(1'b1, 1'b0, 8'h55);
    drainCmp("after drain");
    sendCmd(keb_pkg::CMD_ENABLE);
    repeat (2) @(negedge clk);
    check("overrun flush", overrun, 1'b0);
    // Shorter repeat timing loaded as the system command would
    @(negedge clk);
    rateWe = 1'b1;
    rateDelayMs = 11'h003;
    ratePeriodMs = 11'h002;
    @(negedge clk);
    rateWe = 1'b0;
    // Held key while inhibited stores one make; a response bypasses the store
    allow = 1'b0;
    repeat (4) @(negedge clk);
    keyEv(1'b1, 7'h32, 8'h66, 1'b0);
    repeat (100) @(negedge clk);
    check("held inhibited", fillLevel, 5'h01);
    @(negedge clk);
    respValid = 1'b1;
    respIn = 8'hfa;
    @(negedge clk);
    respValid = 1'b0;
    check("resp valid", respOutValid, 1'b1);
    check("resp byte", respOut, 8'hfa);
    check("resp fill", fillLevel, 5'h01);
    sendCmd(keb_pkg::CMD_ENABLE);
    repeat (2) @(negedge clk);
    check("flush fill", fillLevel, 5'h00);
    allow = 1'b1;
    // Two keys held: only the newer one repeats, 200 cycles of hold
    keyEv(1'b1, 7'h28, 8'h21, 1'b0);
    keyEv(1'b1, 7'h29, 8'h22, 1'b0);
    repeat (200) @(negedge clk);
    // Release before counting so no repeat in flight is lost; break ends the run
    keyEv(1'b0, 7'h29, 8'h22, 1'b0);
    repeat (100) @(negedge clk);
    cntA = 0;
    cntB = 0;
    foreach (gotQ[k]) begin
      if (gotQ[k] === 8'h21) cntA++;
      if (gotQ[k] === 8'h22) cntB++;
    end
    check("older key makes", cntA, 1);
    check("newer key repeats", (cntB >= 17 && cntB <= 19), 1'b1);
    check("repeat stop", {gotQ[gotQ.size()-2], gotQ[gotQ.size()-1]}, 16'hf022);
    gotQ.delete();
    keyEv(1'b0, 7'h28, 8'h21, 1'b0);
    addKey(1'b0, 1'b0, 8'h21);
    drainCmp("older release");
    // Pause key: one make, no repeat, no break
    keyEv(1'b1, 7'h62, 8'h77, 1'b0);
    repeat (100) @(negedge clk);
    keyEv(1'b0, 7'h62, 8'h77, 1'b0);
    addKey(1'b1, 1'b0, 8'h77);
    drainCmp("pause");
    // Set three: key made make-only and non-repeating
    scanSet3 = 1'b1;
    @(negedge clk);
    typeWe = 1'b1;
    typeKey = 7'h2d;
    typeVal = 2'h0;
    @(negedge clk);
    typeWe = 1'b0;
    keyEv(1'b1, 7'h2d, 8'h33, 1'b0);
    repeat (100) @(negedge clk);
    keyEv(1'b0, 7'h2d, 8'h33, 1'b0);
    addKey(1'b1, 1'b0, 8'h33);
    drainCmp("set three type");
    finishTest();
  end
endmodule
`default_nettype wire
